// ---- logic/gpint_top.sv ----
// Pin interrupt detection, status and owner select with AXI4-Lite access
//
// Chosen here: register access over AXI4-Lite.
`include "gpint_params.svh"
`default_nettype none
module gpint_top
    import gpint_pkg::*;
#(
    parameter gpint_port_t PORT = GPINT_PORT_PLAIN
) (
    input  wire logic        aclk,          // System clock
    input  wire logic        aresetn,       // Sync reset, active low
    input  wire logic [11:0] s_axi_awaddr,  // Write address
    input  wire logic        s_axi_awvalid, // Write address valid
    output logic             s_axi_awready, // Write address ready
    input  wire logic [31:0] s_axi_wdata,   // Write data
    input  wire logic [3:0]  s_axi_wstrb,   // Write strobes
    input  wire logic        s_axi_wvalid,  // Write data valid
    output logic             s_axi_wready,  // Write data ready
    output logic [1:0]       s_axi_bresp,   // Write response
    output logic             s_axi_bvalid,  // Write response valid
    input  wire logic        s_axi_bready,  // Write response ready
    input  wire logic [11:0] s_axi_araddr,  // Read address
    input  wire logic        s_axi_arvalid, // Read address valid
    output logic             s_axi_arready, // Read address ready
    output logic [31:0]      s_axi_rdata,   // Read data
    output logic [1:0]       s_axi_rresp,   // Read response
    output logic             s_axi_rvalid,  // Read data valid
    input  wire logic        s_axi_rready,  // Read data ready
    input  wire logic [7:0]  pin_in,        // Port pins, asynchronous
    output logic [7:0]       owner_select_bits, // 1 = hardware owns pin
    output logic             port_irq_out,  // Combined port interrupt
    output logic             converter_trigger_pin // Converter trigger pulse
);

    // ************************************************************
    // Configuration and state
    // ************************************************************
    localparam logic [7:0] OWNER_RST =
        (PORT == GPINT_PORT_B) ? `GPINT_RST_OWNER_B :
        (PORT == GPINT_PORT_C) ? `GPINT_RST_OWNER_C : `GPINT_RST_CFG;

    logic [7:0]  sense_level_bits_q;
    logic [7:0]  dual_edge_bits_q;
    logic [7:0]  polarity_bits_q;
    logic [7:0]  enable_bits_q;
    logic [7:0]  edge_latch_q;
    logic [7:0]  owner_q;
    logic [7:0]  sync1_q;
    logic [7:0]  sync2_q;
    logic [7:0]  sync3_q;
    logic [7:0]  pin_q;
    logic [7:0]  unmasked_status_bits;
    logic [7:0]  gated_status_bits;
    logic [7:0]  edge_hit;
    logic [7:0]  level_hit;
    logic [7:0]  clear_bits;
    logic        aw_held_q;
    logic        w_held_q;
    logic [11:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0]  wstrb_q;
    logic        wr_fire;
    logic        trig_prev_q;

    function automatic logic addr_known(input logic [11:0] a);
        addr_known = (a[1:0] == 2'b00) &&
                     (a >= `GPINT_OFF_SENSE) && (a <= `GPINT_OFF_OWNER);
    endfunction

    // ************************************************************
    // Pin synchroniser, a rise counts once stages two and three agree, a fall as soon as they differ
    // ************************************************************
    // Stages run in reset too, so a high pin gives no false edge after it
    always_ff @(posedge aclk) begin
        sync1_q <= pin_in;
        sync2_q <= sync1_q;
        sync3_q <= sync2_q;
        if (!aresetn) begin
            pin_q <= sync2_q;
        end else begin
            pin_q <= (pin_q & ~(sync2_q ^ sync3_q)) |
                     (sync2_q & (sync2_q ~^ sync3_q));
        end
    end

    // ************************************************************
    // Detection
    // ************************************************************
    logic [7:0] pin_new;
    assign pin_new = (pin_q & ~(sync2_q ^ sync3_q)) |
                     (sync2_q & (sync2_q ~^ sync3_q));

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_pin
            logic rise;
            logic fall;
            assign rise = pin_new[gi] & ~pin_q[gi];
            assign fall = ~pin_new[gi] & pin_q[gi];
            assign edge_hit[gi] = ~sense_level_bits_q[gi] &
                (dual_edge_bits_q[gi] ? (rise | fall) :
                 (polarity_bits_q[gi] ? rise : fall));
            assign level_hit[gi] = sense_level_bits_q[gi] &
                (polarity_bits_q[gi] ? pin_q[gi] : ~pin_q[gi]);
        end
    endgenerate

    // Level pins report the live level, edge pins the latch
    assign unmasked_status_bits = level_hit |
        (edge_latch_q & ~sense_level_bits_q);
    assign gated_status_bits = unmasked_status_bits & enable_bits_q;

    assign wr_fire = (aw_held_q | s_axi_awvalid) &
                     (w_held_q | s_axi_wvalid) & ~s_axi_bvalid;
    logic [11:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0]  wr_strb;
    assign wr_addr = aw_held_q ? awaddr_q : s_axi_awaddr;
    assign wr_data = w_held_q ? wdata_q : s_axi_wdata;
    assign wr_strb = w_held_q ? wstrb_q : s_axi_wstrb;
    assign clear_bits = (wr_fire && wr_addr == `GPINT_OFF_CLEAR &&
                         wr_strb[0]) ? wr_data[7:0] : 8'h00;

    // Set wins over clear in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            edge_latch_q <= 8'h00;
        end else begin
            edge_latch_q <= (edge_latch_q & ~clear_bits) | edge_hit;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            port_irq_out          <= 1'b0;
            converter_trigger_pin <= 1'b0;
            trig_prev_q           <= 1'b0;
        end else begin
            port_irq_out <= |gated_status_bits;
            trig_prev_q  <= gated_status_bits[`GPINT_TRIG_PIN];
            converter_trigger_pin <= (PORT == GPINT_PORT_B) &&
                gated_status_bits[`GPINT_TRIG_PIN] && !trig_prev_q;
        end
    end
    assign owner_select_bits = owner_q;

    // ************************************************************
    // Register writes
    // ************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sense_level_bits_q <= `GPINT_RST_CFG;
            dual_edge_bits_q   <= `GPINT_RST_CFG;
            polarity_bits_q    <= `GPINT_RST_CFG;
            enable_bits_q      <= `GPINT_RST_CFG;
            owner_q            <= OWNER_RST;
        end else if (wr_fire && wr_strb[0]) begin
            unique case (wr_addr)
                `GPINT_OFF_SENSE:  sense_level_bits_q <= wr_data[7:0];
                `GPINT_OFF_DUAL:   dual_edge_bits_q   <= wr_data[7:0];
                `GPINT_OFF_POL:    polarity_bits_q    <= wr_data[7:0];
                `GPINT_OFF_ENABLE: enable_bits_q <= wr_data[7:0];
                `GPINT_OFF_OWNER:  owner_q            <= wr_data[7:0];
                default: ;
            endcase
        end
    end

    // ************************************************************
    // AXI4-Lite write channel
    // ************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q     <= 1'b0;
            w_held_q      <= 1'b0;
            awaddr_q      <= 12'h000;
            wdata_q       <= 32'h0000_0000;
            wstrb_q       <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `GPINT_RESP_OKAY;
        end else begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            if (wr_fire) begin
                aw_held_q    <= 1'b0;
                w_held_q     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= addr_known(wr_addr) ?
                                `GPINT_RESP_OKAY : `GPINT_RESP_SLVERR;
                s_axi_awready <= ~aw_held_q;
                s_axi_wready  <= ~w_held_q;
            end else begin
                // Ready is given one cycle late, so hold what arrived
                if (s_axi_awvalid && !aw_held_q && !s_axi_bvalid) begin
                    aw_held_q     <= 1'b1;
                    awaddr_q      <= s_axi_awaddr;
                    s_axi_awready <= 1'b1;
                end
                if (s_axi_wvalid && !w_held_q && !s_axi_bvalid) begin
                    w_held_q     <= 1'b1;
                    wdata_q      <= s_axi_wdata;
                    wstrb_q      <= s_axi_wstrb;
                    s_axi_wready <= 1'b1;
                end
                if (s_axi_bvalid && s_axi_bready) begin
                    s_axi_bvalid <= 1'b0;
                end
            end
        end
    end

    // ************************************************************
    // AXI4-Lite read channel
    // ************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `GPINT_RESP_OKAY;
        end else begin
            s_axi_arready <= 1'b0;
            if (s_axi_rvalid) begin
                if (s_axi_rready) begin
                    s_axi_rvalid <= 1'b0;
                end
            end else if (s_axi_arvalid && !s_axi_arready) begin
                s_axi_arready <= 1'b1;
                s_axi_rvalid  <= 1'b1;
                s_axi_rresp   <= addr_known(s_axi_araddr) ?
                                 `GPINT_RESP_OKAY : `GPINT_RESP_SLVERR;
                unique case (s_axi_araddr)
                    `GPINT_OFF_SENSE:
                        s_axi_rdata <= {24'h00_0000, sense_level_bits_q};
                    `GPINT_OFF_DUAL:
                        s_axi_rdata <= {24'h00_0000, dual_edge_bits_q};
                    `GPINT_OFF_POL:
                        s_axi_rdata <= {24'h00_0000, polarity_bits_q};
                    `GPINT_OFF_ENABLE:
                        s_axi_rdata <= {24'h00_0000, enable_bits_q};
                    `GPINT_OFF_RAW:
                        s_axi_rdata <= {24'h00_0000, unmasked_status_bits};
                    `GPINT_OFF_GATED:
                        s_axi_rdata <= {24'h00_0000, gated_status_bits};
                    `GPINT_OFF_OWNER:
                        s_axi_rdata <= {24'h00_0000, owner_q};
                    default:
                        s_axi_rdata <= 32'h0000_0000;
                endcase
            end
        end
    end

endmodule
`default_nettype wire

// ---- logic/gpint_params.svh ----
// Constants for the port pin interrupt and owner select block
`ifndef GPINT_PARAMS_SVH
`define GPINT_PARAMS_SVH
`define GPINT_OFF_SENSE    12'h404
`define GPINT_OFF_DUAL     12'h408
`define GPINT_OFF_POL      12'h40C
`define GPINT_OFF_ENABLE   12'h410
`define GPINT_OFF_RAW      12'h414
`define GPINT_OFF_GATED    12'h418
`define GPINT_OFF_CLEAR    12'h41C
`define GPINT_OFF_OWNER    12'h420
`define GPINT_RST_CFG      8'h00
`define GPINT_RST_OWNER_B  8'h80
`define GPINT_RST_OWNER_C  8'h0F
`define GPINT_TRIG_PIN     4
`define GPINT_RESP_OKAY    2'b00
`define GPINT_RESP_SLVERR  2'b10
`endif

// ---- logic/gpint_pkg.sv ----
// Types for the port pin interrupt and owner select block
`default_nettype none
package gpint_pkg;
    typedef enum {GPINT_PORT_PLAIN, GPINT_PORT_B, GPINT_PORT_C} gpint_port_t;
endpackage
`default_nettype wire

// ---- verification/gpint_pins.sv ----
// Pin driver model standing in for the external port pins
`default_nettype none
module gpint_pins (
    input  wire logic       aclk,    // System clock
    input  wire logic [7:0] level,   // Commanded pin levels
    output var  logic [7:0] pin_in   // Pins seen by the block
);
    timeunit 1ns;
    timeprecision 1ps;
    // Pins move just after an edge, like a real asynchronous source
    always @(posedge aclk) pin_in <= level;
endmodule
`default_nettype wire

// ---- verification/gpint_checker.sv ----
// Output and bus checks for the pin interrupt block
`include "gpint_params.svh"
`default_nettype none
module gpint_checker
    import gpint_pkg::*;
#(
    parameter gpint_port_t PORT = GPINT_PORT_PLAIN
) (
    input wire logic        aclk,                  // Clock
    input wire logic        aresetn,               // Reset, active low
    input wire logic        s_axi_bvalid,          // Write response valid
    input wire logic        s_axi_bready,          // Write response ready
    input wire logic [31:0] s_axi_rdata,           // Read data
    input wire logic [1:0]  s_axi_rresp,           // Read response
    input wire logic        s_axi_rvalid,          // Read data valid
    input wire logic        s_axi_rready,          // Read data ready
    input wire logic [7:0]  owner_select_bits,     // Owner select
    input wire logic        port_irq_out,          // Port interrupt
    input wire logic        converter_trigger_pin  // Converter trigger
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] RST = (PORT == GPINT_PORT_B) ? `GPINT_RST_OWNER_B
        : (PORT == GPINT_PORT_C) ? `GPINT_RST_OWNER_C : `GPINT_RST_CFG;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    AST_RST_OWNER: assert property (disable iff (1'b0)
        !aresetn |=> owner_select_bits == RST) else $error("owner reset");
    AST_RST_IRQ: assert property (disable iff (1'b0)
        !aresetn |=> !port_irq_out) else $error("irq after reset");
    AST_OWNER_WR: assert property ($changed(owner_select_bits)
        |-> $rose(s_axi_bvalid)) else $error("owner moved alone");
    AST_RSV_ZERO: assert property (s_axi_rvalid
        |-> s_axi_rdata[31:8] == 24'h000000) else $error("upper bits");
    AST_ERR_ZERO: assert property (s_axi_rvalid
        && s_axi_rresp == `GPINT_RESP_SLVERR
        |-> s_axi_rdata == 32'h00000000) else $error("error data");
    AST_BHOLD: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid) else $error("bvalid dropped");
    AST_RHOLD: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("r dropped");
    AST_TRIG_PULSE: assert property (converter_trigger_pin
        |=> !converter_trigger_pin) else $error("trigger too long");
    AST_TRIG_PORT: assert property (converter_trigger_pin
        |-> PORT == GPINT_PORT_B) else $error("trigger on wrong port");
    AST_TRIG_IRQ: assert property (converter_trigger_pin
        |-> ##[0:2] port_irq_out) else $error("trigger without irq");
endmodule
`default_nettype wire

// ---- verification/gpint_top_bench.sv ----
// Self-checking bench for the pin interrupt block
`include "gpint_params.svh"
`default_nettype none
module gpint_top_bench;
    import gpint_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [7:0] s, d, p, e, raw, gat; logic irq;} gpint_row_t;
    // Pins go 0F to F0: low nibble falls, high nibble rises
    gpint_row_t rows [6] = '{
        '{8'h00, 8'h00, 8'hFF, 8'hFF, 8'hF0, 8'hF0, 1'b1},
        '{8'h00, 8'h00, 8'h00, 8'h0F, 8'h0F, 8'h0F, 1'b1},
        '{8'h00, 8'hFF, 8'h00, 8'h00, 8'hFF, 8'h00, 1'b0},
        '{8'hFF, 8'h00, 8'hFF, 8'h80, 8'hF0, 8'h80, 1'b1},
        '{8'hFF, 8'h00, 8'h00, 8'h01, 8'h0F, 8'h01, 1'b1},
        '{8'h0F, 8'hF0, 8'h00, 8'h00, 8'hFF, 8'h00, 1'b0}};
    logic        aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
    logic        arvalid = 0, rready = 0, awready, wready, bvalid, arready;
    logic        rvalid, irq, trig;
    logic [11:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata, d;
    logic [1:0]  bresp, rresp, r;
    logic [7:0]  pin_lvl = 0, pin_in, owner;
    int          fails = 0, compares = 0, pulses = 0, base = 0;
    always #4 aclk = ~aclk;
    always @(posedge aclk) if (trig === 1'b1) pulses <= pulses + 1;
    gpint_pins u_pins (.aclk(aclk), .level(pin_lvl), .pin_in(pin_in));
    gpint_top #(.PORT(GPINT_PORT_B)) dut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .pin_in(pin_in), .owner_select_bits(owner),
        .port_irq_out(irq), .converter_trigger_pin(trig));
    task automatic end_of_test();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] v);
        int n;
        awaddr <= a;
        wdata <= {24'h000000, v};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
            if (bvalid === 1'b1) break;
        end
        bready <= 1'b0;
        // Idle edge, so the next call never reassigns a signal in this step
        @(posedge aclk);
        if (n == 50) begin
            fails++;
            end_of_test();
        end
    endtask
    task automatic rd(input logic [11:0] a);
        int n;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (arready === 1'b1) arvalid <= 1'b0;
            if (rvalid === 1'b1) break;
        end
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        @(posedge aclk);
        if (n == 50) begin
            fails++;
            end_of_test();
        end
    endtask
    task automatic rst_chk();
        for (int a = 12'h404; a <= 12'h420; a += 4) begin
            rd(a[11:0]);
            chk(d, (a == `GPINT_OFF_OWNER) ? 32'h80 : 32'h0);
            chk({30'h0, r}, {30'h0, `GPINT_RESP_OKAY});
        end
        chk({24'h0, owner}, 32'h80);
    endtask
    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rst_chk();
        foreach (rows[i]) begin
            pin_lvl <= 8'h0F;
            repeat (10) @(posedge aclk);
            wr(`GPINT_OFF_SENSE, rows[i].s);
            wr(`GPINT_OFF_DUAL, rows[i].d);
            wr(`GPINT_OFF_POL, rows[i].p);
            wr(`GPINT_OFF_ENABLE, rows[i].e);
            wr(`GPINT_OFF_CLEAR, 8'hFF);
            base = pulses;
            pin_lvl <= 8'hF0;
            repeat (10) @(posedge aclk);
            rd(`GPINT_OFF_RAW);
            chk(d, {24'h0, rows[i].raw});
            rd(`GPINT_OFF_GATED);
            chk(d, {24'h0, rows[i].gat});
            chk({31'h0, irq}, {31'h0, rows[i].irq});
            chk(pulses - base, {31'h0, rows[i].gat[4]});
        end
        // Zero clear bits must leave edge latches alone
        wr(`GPINT_OFF_CLEAR, 8'h00);
        rd(`GPINT_OFF_RAW);
        chk(d, 32'hFF);
        wr(`GPINT_OFF_CLEAR, 8'hF0);
        wr(`GPINT_OFF_RAW, 8'hFF);
        rd(`GPINT_OFF_RAW);
        chk(d, 32'h0F);
        wr(`GPINT_OFF_ENABLE, 8'h01);
        repeat (3) @(posedge aclk);
        chk({31'h0, irq}, 32'h1);
        wr(`GPINT_OFF_ENABLE, 8'hF0);
        repeat (3) @(posedge aclk);
        chk({31'h0, irq}, 32'h0);
        rd(12'h500);
        chk({30'h0, r}, {30'h0, `GPINT_RESP_SLVERR});
        wr(`GPINT_OFF_OWNER, 8'h5A);
        rd(`GPINT_OFF_OWNER);
        chk(d, 32'h5A);
        chk({24'h0, owner}, 32'h5A);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rst_chk();
        end_of_test();
    end
endmodule
bind gpint_top gpint_checker #(.PORT(PORT)) u_chk (.aclk(aclk),
    .aresetn(aresetn), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .owner_select_bits(owner_select_bits),
    .port_irq_out(port_irq_out),
    .converter_trigger_pin(converter_trigger_pin));
`default_nettype wire
